// File: fim_consts.svh
// Purpose: Named offsets, resets, field positions and timing for the fault interrupt block
// Assumes: APB byte address is four times the register index
// Notes:   Included by bare name from the design files
`ifndef FIM_CONSTS_SVH
`define FIM_CONSTS_SVH

// Register indexes (byte address = index * 4)
`define FIM_IDX_CFG        6'h28
`define FIM_IDX_CH_MASK    6'h2A
`define FIM_IDX_TYPE_MASK  6'h2B
`define FIM_IDX_LATCH      6'h2C
`define FIM_IDX_SYS_MASK   6'h30

// Reset values
`define FIM_RST_CFG        8'h00
`define FIM_RST_CH_MASK    8'h03
`define FIM_RST_TYPE_MASK  8'h00
`define FIM_RST_LATCH      4'h0
`define FIM_RST_SYS_MASK   4'hF

// Configuration fields
`define FIM_CFG_POL        7
`define FIM_CFG_MODE_HI    6
`define FIM_CFG_MODE_LO    5
`define FIM_CFG_RDSEL      2
`define FIM_CFG_CLRPOL     0
`define FIM_CFG_WMASK      8'hE5

// Event field of the latched and system mask registers
`define FIM_EVT_HI         7
`define FIM_EVT_LO         4
`define FIM_EVT_CLKERR     3
`define FIM_EVT_PLLLOCK    2
`define FIM_EVT_OVTEMP     1
`define FIM_EVT_OVCUR      0

// Channel mask field: bit 7 is channel 1, bit 4 is channel 4
`define FIM_CH_MSB         7

// Interrupt pulse timing
`define FIM_CLK_MHZ        250
`define FIM_PULSE_US       2000
`define FIM_PULSE_CYC      (`FIM_PULSE_US * `FIM_CLK_MHZ)

`endif

// File: fim_pkg.sv
// Purpose: Types shared by the fault interrupt block
// Assumes: Nothing beyond the constants header
// Notes:   Mode codes follow the event mode field
package fim_pkg;
	typedef enum logic [1:0] {
		FIM_MODE_LEVEL,
		FIM_MODE_UNUSED,
		FIM_MODE_REPEAT,
		FIM_MODE_ONCE
	} fim_mode_t;

	typedef enum logic [1:0] {
		FIM_PS_IDLE,
		FIM_PS_ON,
		FIM_PS_OFF
	} fim_pulse_st_t;

	typedef logic [7:0] fim_byte_t;
endpackage

// File: fim_evt_if.sv
// Purpose: Carries live events, clear requests and latched state to the latch module
// Assumes: Single pclk domain
// Notes:   Clear is a one-cycle vector pulse
`timescale 1ns/1ps
`default_nettype none
interface fim_evt_if #(parameter int N = 4);
	logic [N-1:0] live;     // Live event status
	logic [N-1:0] clr;      // Clear request per bit
	logic         policy;   // Clear policy bit
	logic [N-1:0] latched;  // Latched events

	modport latch (input live, input clr, input policy, output latched);
	modport ctrl  (output live, output clr, output policy, input latched);
endinterface
`default_nettype wire

// File: fim_event_latch.sv
// Purpose: Sticky event bits with selectable clear policy
// Assumes: Clear pulses come from the register access logic
// Notes:   A set in the clearing cycle always wins
`timescale 1ns/1ps
`default_nettype none
`include "fim_consts.svh"
module fim_event_latch #(
	parameter int N = 4
) (
	input  wire logic  pclk,     // Block clock
	input  wire logic  presetn,  // Async reset, low
	fim_evt_if.latch   evt       // Event carrier
);
	import fim_pkg::*;

	logic [N-1:0] live_q_reg;
	logic [N-1:0] lat_reg;
	logic [N-1:0] set_vec;
	logic [N-1:0] clr_vec;

	// Set and clear terms per policy
	always_comb begin
		set_vec = evt.policy ? (evt.live & ~live_q_reg) : evt.live;
		clr_vec = evt.policy ? evt.clr : (evt.clr & ~evt.live);
	end

	// Previous live level for rise detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_q_reg <= '0;
		end else begin
			live_q_reg <= evt.live;
		end
	end

	// Sticky bits, set over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat_reg <= N'(`FIM_RST_LATCH);
		end else begin
			lat_reg <= (lat_reg & ~clr_vec) | set_vec;
		end
	end

	assign evt.latched = lat_reg;
endmodule
`default_nettype wire

// File: fim_top.sv
// Purpose: Fault mask, latched system events and interrupt pin behind APB
// Assumes: Live fault and event levels are synchronous to pclk
// Notes:   Read of the latched register clears what it returned, except bits still live while the clear policy bit is 0
`timescale 1ns/1ps
`default_nettype none
`include "fim_consts.svh"
module fim_top
	import fim_pkg::*;
#(
	parameter int          ADDR_W    = 8,
	parameter int          NCH       = 4,
	parameter int unsigned PULSE_CYC = `FIM_PULSE_CYC
) (
	input  wire logic            pclk,             // APB clock
	input  wire logic            presetn,          // Async reset, low
	input  wire logic            psel,             // APB select
	input  wire logic            penable,          // APB enable
	input  wire logic            pwrite,           // APB direction
	input  wire logic [ADDR_W-1:0] paddr,          // APB byte address
	input  wire logic [31:0]     pwdata,           // APB write data
	input  wire logic [3:0]      pstrb,            // APB byte strobes
	output logic      [31:0]     prdata,           // APB read data
	output logic                 pready,           // APB ready
	output logic                 pslverr,          // APB error
	input  wire logic [3:0]      sys_event_live,   // Clk err, lock, temp, current
	input  wire logic [NCH*8-1:0] chan_fault_live, // Per channel, 8 fault types
	output logic                 interrupt_out     // Interrupt pin
);
	import fim_pkg::*;

	localparam int unsigned PERIOD_CYC = 2 * PULSE_CYC;

	if (NCH != 4 || ADDR_W < 8 || PULSE_CYC < 1) begin : g_chk
		$error("fim_top: unsupported parameter values");
	end

	// Register index of an aligned byte address
	function automatic logic [5:0] fim_idx(input logic [ADDR_W-1:0] a);
		fim_idx = a[7:2];
	endfunction

	// Mapped and aligned address check
	function automatic logic fim_hit(input logic [ADDR_W-1:0] a);
		logic [5:0] i;
		i = a[7:2];
		fim_hit = (a[1:0] == 2'b00) && ((a >> 8) == '0) &&
			(i == `FIM_IDX_CFG || i == `FIM_IDX_CH_MASK || i == `FIM_IDX_TYPE_MASK ||
			 i == `FIM_IDX_LATCH || i == `FIM_IDX_SYS_MASK);
	endfunction

	// Any unmasked channel fault of an unmasked type
	function automatic logic fim_chan_pend(input logic [NCH*8-1:0] live,
		input fim_byte_t chm, input fim_byte_t tym);
		logic r;
		r = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			if (!chm[`FIM_CH_MSB - c]) begin
				r = r | (|(live[c*8 +: 8] & ~tym));
			end
		end
		fim_chan_pend = r;
	endfunction

	fim_byte_t     cfg_reg;
	fim_byte_t     ch_mask_reg;
	fim_byte_t     type_mask_reg;
	logic [3:0]    sys_mask_reg;
	logic [31:0]   prdata_reg;
	logic          pready_reg;
	logic          pslverr_reg;
	logic          irq_reg;
	logic          pend_q_reg;
	fim_pulse_st_t pst_reg;
	logic [31:0]   cnt_reg;

	logic          setup;
	logic          acc;
	logic          wr_ok;
	logic [5:0]    idx;
	logic [3:0]    lat;
	logic [3:0]    lat_view;
	logic [3:0]    clr_vec;
	logic          sys_pend;
	logic          chan_pend;
	logic          any_pend;
	logic          active;
	fim_mode_t     mode;
	logic [31:0]   rd_val;

	fim_evt_if #(.N(4)) evt_if ();

	fim_event_latch #(.N(4)) u_latch (
		.pclk    (pclk),
		.presetn (presetn),
		.evt     (evt_if.latch)
	);

	// Bus phase decode
	assign setup = psel && !penable;
	assign acc   = psel && penable && pready_reg;
	assign idx   = fim_idx(paddr);
	assign wr_ok = acc && pwrite && pstrb[0] && fim_hit(paddr);
	assign mode  = fim_mode_t'(cfg_reg[`FIM_CFG_MODE_HI:`FIM_CFG_MODE_LO]);

	// Latched view and readback filter
	assign lat      = evt_if.latched;
	assign lat_view = cfg_reg[`FIM_CFG_RDSEL] ? (lat & ~sys_mask_reg) : lat;

	// Clear on read of shown bits, or write one to clear
	always_comb begin
		clr_vec = 4'h0;
		if (acc && idx == `FIM_IDX_LATCH && fim_hit(paddr)) begin
			if (!pwrite) begin
				clr_vec = prdata_reg[`FIM_EVT_HI:`FIM_EVT_LO];
			end else if (pstrb[0]) begin
				clr_vec = pwdata[`FIM_EVT_HI:`FIM_EVT_LO];
			end
		end
	end

	// Feed the latch carrier
	assign evt_if.live   = sys_event_live;
	assign evt_if.clr    = clr_vec;
	assign evt_if.policy = cfg_reg[`FIM_CFG_CLRPOL];

	// Read mux
	always_comb begin
		rd_val = 32'h0000_0000;
		case (idx)
			`FIM_IDX_CFG:       rd_val[7:0] = cfg_reg;
			`FIM_IDX_CH_MASK:   rd_val[7:0] = ch_mask_reg;
			`FIM_IDX_TYPE_MASK: rd_val[7:0] = type_mask_reg;
			`FIM_IDX_LATCH:     rd_val[7:0] = {lat_view, 4'h0};
			`FIM_IDX_SYS_MASK:  rd_val[7:0] = {sys_mask_reg, 4'h0};
			default:            rd_val = 32'h0000_0000;
		endcase
		if (!fim_hit(paddr)) begin
			rd_val = 32'h0000_0000;
		end
	end

	// Bus answer: ready in first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else if (setup) begin
			pready_reg  <= 1'b1;
			pslverr_reg <= !fim_hit(paddr);
			prdata_reg  <= pwrite ? 32'h0000_0000 : rd_val;
		end else begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	// Configuration register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `FIM_RST_CFG;
		end else if (wr_ok && idx == `FIM_IDX_CFG) begin
			cfg_reg <= pwdata[7:0] & `FIM_CFG_WMASK;
		end
	end

	// Channel fault mask, reserved bits stored as written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_mask_reg <= `FIM_RST_CH_MASK;
		end else if (wr_ok && idx == `FIM_IDX_CH_MASK) begin
			ch_mask_reg <= pwdata[7:0];
		end
	end

	// Fault type mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			type_mask_reg <= `FIM_RST_TYPE_MASK;
		end else if (wr_ok && idx == `FIM_IDX_TYPE_MASK) begin
			type_mask_reg <= pwdata[7:0];
		end
	end

	// System event mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_mask_reg <= `FIM_RST_SYS_MASK;
		end else if (wr_ok && idx == `FIM_IDX_SYS_MASK) begin
			sys_mask_reg <= pwdata[`FIM_EVT_HI:`FIM_EVT_LO];
		end
	end

	// Pending request terms
	assign sys_pend  = |(lat & ~sys_mask_reg);
	assign chan_pend = fim_chan_pend(chan_fault_live, ch_mask_reg, type_mask_reg);
	assign any_pend  = sys_pend || chan_pend;

	// Pulse sequencer for repeat and one-shot modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pst_reg    <= FIM_PS_IDLE;
			cnt_reg    <= 32'h0000_0000;
			pend_q_reg <= 1'b0;
		end else begin
			pend_q_reg <= any_pend;
			case (pst_reg)
				FIM_PS_IDLE: begin
					cnt_reg <= 32'h0000_0000;
					if ((mode == FIM_MODE_REPEAT && any_pend) ||
						(mode == FIM_MODE_ONCE && any_pend && !pend_q_reg)) begin
						pst_reg <= FIM_PS_ON;
					end
				end
				FIM_PS_ON: begin
					if (mode != FIM_MODE_REPEAT && mode != FIM_MODE_ONCE) begin
						pst_reg <= FIM_PS_IDLE;
					end else if (cnt_reg == 32'(PULSE_CYC - 1)) begin
						cnt_reg <= 32'h0000_0000;
						pst_reg <= (mode == FIM_MODE_REPEAT) ? FIM_PS_OFF : FIM_PS_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 32'h0000_0001;
					end
				end
				FIM_PS_OFF: begin
					if (mode != FIM_MODE_REPEAT) begin
						pst_reg <= FIM_PS_IDLE;
					end else if (cnt_reg == 32'(PERIOD_CYC - PULSE_CYC - 1)) begin
						cnt_reg <= 32'h0000_0000;
						pst_reg <= any_pend ? FIM_PS_ON : FIM_PS_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 32'h0000_0001;
					end
				end
				default: begin
					pst_reg <= FIM_PS_IDLE;
					cnt_reg <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Active request per event mode; unused code acts as level
	assign active = (mode == FIM_MODE_REPEAT || mode == FIM_MODE_ONCE) ?
		(pst_reg == FIM_PS_ON) : any_pend;

	// Pin level per polarity, idle high after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b1;
		end else begin
			irq_reg <= cfg_reg[`FIM_CFG_POL] ? active : !active;
		end
	end

	assign prdata        = prdata_reg;
	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg;
	assign interrupt_out = irq_reg;

	// Checks
	property p_ch_mask_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr_ok && idx == `FIM_IDX_CH_MASK) |=> (ch_mask_reg == $past(pwdata[7:0]));
	endproperty
	a_ch_mask_wr: assert property (p_ch_mask_wr) else $error("channel mask write lost");

	property p_ch_mask_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr_ok && idx == `FIM_IDX_CH_MASK) |=> $stable(ch_mask_reg);
	endproperty
	a_ch_mask_hold: assert property (p_ch_mask_hold) else $error("channel mask changed");

	property p_type_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr_ok && idx == `FIM_IDX_TYPE_MASK) |=> (type_mask_reg == $past(pwdata[7:0]));
	endproperty
	a_type_wr: assert property (p_type_wr) else $error("type mask write lost");

	property p_type_block;
		@(posedge pclk) disable iff (!presetn)
		(type_mask_reg == 8'hFF || ch_mask_reg[7:4] == 4'hF) |-> !chan_pend;
	endproperty
	a_type_block: assert property (p_type_block) else $error("masked fault pending");

	property p_rd_low_zero;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && idx == `FIM_IDX_LATCH) |-> (prdata[3:0] == 4'h0);
	endproperty
	a_rd_low_zero: assert property (p_rd_low_zero) else $error("reserved latch bits set");

	property p_evt_set;
		@(posedge pclk) disable iff (!presetn)
		(sys_event_live[`FIM_EVT_CLKERR] &&
		 (!cfg_reg[`FIM_CFG_CLRPOL] || !$past(sys_event_live[`FIM_EVT_CLKERR])))
		|=> lat[`FIM_EVT_CLKERR];
	endproperty
	a_evt_set: assert property (p_evt_set) else $error("clock error not latched");

	property p_keep_live;
		@(posedge pclk) disable iff (!presetn)
		(!cfg_reg[`FIM_CFG_CLRPOL] && clr_vec[`FIM_EVT_CLKERR] &&
		 sys_event_live[`FIM_EVT_CLKERR]) |=> lat[`FIM_EVT_CLKERR];
	endproperty
	a_keep_live: assert property (p_keep_live) else $error("live event bit cleared");

	property p_force_clr;
		@(posedge pclk) disable iff (!presetn)
		(cfg_reg[`FIM_CFG_CLRPOL] && $stable(cfg_reg) && clr_vec[`FIM_EVT_CLKERR] &&
		 sys_event_live[`FIM_EVT_CLKERR] && $past(sys_event_live[`FIM_EVT_CLKERR]))
		|=> !lat[`FIM_EVT_CLKERR];
	endproperty
	a_force_clr: assert property (p_force_clr) else $error("forced clear ignored");

	property p_rd_hidden;
		@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && idx == `FIM_IDX_LATCH && cfg_reg[`FIM_CFG_RDSEL] &&
		 sys_mask_reg[`FIM_EVT_CLKERR]) |=> !prdata[`FIM_EVT_HI];
	endproperty
	a_rd_hidden: assert property (p_rd_hidden) else $error("masked event shown");

	property p_level_irq;
		@(posedge pclk) disable iff (!presetn)
		(mode == FIM_MODE_LEVEL && cfg_reg[`FIM_CFG_POL] && any_pend) |=> interrupt_out;
	endproperty
	a_level_irq: assert property (p_level_irq) else $error("level irq missing");

	property p_pol_low;
		@(posedge pclk) disable iff (!presetn)
		(mode == FIM_MODE_LEVEL && !cfg_reg[`FIM_CFG_POL] && sys_pend) |=> !interrupt_out;
	endproperty
	a_pol_low: assert property (p_pol_low) else $error("active low irq missing");

	property p_unmasked_irq;
		@(posedge pclk) disable iff (!presetn)
		(mode == FIM_MODE_LEVEL && (lat & ~sys_mask_reg) == 4'h0 && !chan_pend)
		|=> (interrupt_out == !$past(cfg_reg[`FIM_CFG_POL]));
	endproperty
	a_unmasked_irq: assert property (p_unmasked_irq) else $error("irq without cause");

	property p_answer;
		@(posedge pclk) disable iff (!presetn)
		setup |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no ready after setup");

	c_read_clear: cover property (@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite && idx == `FIM_IDX_LATCH && prdata[7:4] != 4'h0));
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) (acc && pslverr));
	c_pulse_on: cover property (@(posedge pclk) disable iff (!presetn)
		(pst_reg == FIM_PS_ON && mode == FIM_MODE_ONCE));
endmodule
`default_nettype wire

// File: fim_testbench.sv
// Purpose: Self-checking bench for the fault masks, latched events and interrupt pin
// Assumes: APB slave answers with pready; pulse length shortened to 8 cycles
// Notes:   The pin is sampled three edges after each cause so it has settled
`timescale 1ns/1ps
`default_nettype none
`include "fim_consts.svh"
module testbench;
	import fim_pkg::*;

	localparam logic [7:0] A_CFG = {`FIM_IDX_CFG, 2'b00};
	localparam logic [7:0] A_CH  = {`FIM_IDX_CH_MASK, 2'b00};
	localparam logic [7:0] A_TY  = {`FIM_IDX_TYPE_MASK, 2'b00};
	localparam logic [7:0] A_LT  = {`FIM_IDX_LATCH, 2'b00};
	localparam logic [7:0] A_SM  = {`FIM_IDX_SYS_MASK, 2'b00};

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  sys_event_live;
	logic [31:0] chan_fault_live;
	logic        interrupt_out;
	int          fail_count;
	int          comparisons;
	logic        pol;
	logic [31:0] rd_v;
	logic        err_v;

	fim_top #(.ADDR_W(8), .NCH(4), .PULSE_CYC(8)) DUT (
		.pclk            (pclk),
		.presetn         (presetn),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.pstrb           (pstrb),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.sys_event_live  (sys_event_live),
		.chan_fault_live (chan_fault_live),
		.interrupt_out   (interrupt_out)
	);

	// Clock, 4 ns period
	always #2 pclk = ~pclk;

	// Verdict and end of run
	task automatic complete_run();
		if (fail_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Compare a data word
	task automatic check_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask

	// Compare a single flag
	task automatic check_bit(input string nm, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			$display("[ERR] %s expected %b seen %b", nm, exp, got);
			fail_count++;
		end
	endtask

	// One APB transfer; entered and left just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd_v  = prdata;
		err_v = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			$display("[ERR] pready expected 1 seen %b", pready);
			fail_count++;
			complete_run();
		end else begin
			@(posedge pclk);
		end
	endtask

	// Register write of one byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d}, 4'hF);
	endtask

	// Register read with expected byte
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0, 4'hF);
		check_word($sformatf("prdata at %h", a), {24'h0, e}, rd_v);
	endtask

	// Pin check: asserted level follows the polarity setting
	task automatic pin(input logic act);
		repeat (3) @(posedge pclk);
		check_bit("interrupt_out", act ? pol : ~pol, interrupt_out);
	endtask

	// One-cycle pulse on a system event
	task automatic pulse(input int k);
		sys_event_live <= 4'h1 << k;
		@(posedge pclk);
		sys_event_live <= 4'h0;
		@(posedge pclk);
	endtask

	// Main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		sys_event_live = 4'h0;
		chan_fault_live = 32'h0;
		fail_count = 0;
		comparisons = 0;
		pol = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		check_bit("interrupt_out", 1'b1, interrupt_out);
		rd(A_CFG, 8'h00);
		rd(A_CH, 8'h03);
		rd(A_TY, 8'h00);
		rd(A_LT, 8'h00);
		rd(A_SM, 8'hF0);
		wr(A_CH, 8'hF3);
		rd(A_CH, 8'hF3);
		wr(A_TY, 8'hA5);
		rd(A_TY, 8'hA5);
		apb(1'b1, A_TY, 32'h5A, 4'h0);
		rd(A_TY, 8'hA5);
		wr(A_LT, 8'h0F);
		rd(A_LT, 8'h00);
		wr(A_CFG, 8'hFF);
		rd(A_CFG, 8'hE5);
		wr(A_CFG, 8'h00);
		apb(1'b0, 8'h04, 32'h0, 4'hF);
		check_bit("pslverr", 1'b1, err_v);
		check_word("prdata unmapped", 32'h0, rd_v);
		apb(1'b0, 8'hA9, 32'h0, 4'hF);
		check_bit("pslverr", 1'b1, err_v);
		wr(A_CH, 8'h03);
		wr(A_TY, 8'h00);
		pin(1'b0);
		// Every fault live but all types, then all channels, masked
		chan_fault_live <= 32'hFFFF_FFFF;
		wr(A_TY, 8'hFF);
		pin(1'b0);
		wr(A_TY, 8'h00);
		wr(A_CH, 8'hF3);
		pin(1'b0);
		wr(A_CH, 8'h03);
		chan_fault_live <= 32'h0;
		pin(1'b0);
		// Every channel against every fault type
		for (int c = 0; c < 4; c++) begin
			for (int t = 0; t < 8; t++) begin
				chan_fault_live <= 32'h1 << (c * 8 + t);
				pin(1'b1);
				wr(A_TY, 8'h01 << t);
				pin(1'b0);
				wr(A_TY, ~(8'h01 << t));
				pin(1'b1);
				wr(A_TY, 8'h00);
				wr(A_CH, (8'h80 >> c) | 8'h03);
				pin(1'b0);
				wr(A_CH, (8'hF0 & ~(8'h80 >> c)) | 8'h03);
				pin(1'b1);
				wr(A_CH, 8'h03);
				chan_fault_live <= 32'h0;
				pin(1'b0);
			end
		end
		// Each system event latches, interrupts and clears on read
		wr(A_SM, 8'h00);
		for (int k = 0; k < 4; k++) begin
			pulse(k);
			pin(1'b1);
			rd(A_LT, 8'h10 << k);
			rd(A_LT, 8'h00);
			pin(1'b0);
		end
		// Clear policy with the live event held high
		sys_event_live <= 4'h8;
		pin(1'b1);
		rd(A_LT, 8'h80);
		rd(A_LT, 8'h80);
		wr(A_CFG, 8'h01);
		rd(A_LT, 8'h80);
		rd(A_LT, 8'h00);
		pin(1'b0);
		sys_event_live <= 4'h0;
		@(posedge pclk);
		sys_event_live <= 4'h8;
		pin(1'b1);
		rd(A_LT, 8'h80);
		sys_event_live <= 4'h0;
		wr(A_CFG, 8'h00);
		rd(A_LT, 8'h00);
		// Readback select hides masked events
		wr(A_SM, 8'hE0);
		wr(A_CFG, 8'h04);
		pulse(3);
		pulse(0);
		pin(1'b1);
		rd(A_LT, 8'h10);
		wr(A_CFG, 8'h00);
		rd(A_LT, 8'h80);
		rd(A_LT, 8'h00);
		pin(1'b0);
		// Active-high pin
		wr(A_CFG, 8'h80);
		pol = 1'b1;
		pin(1'b0);
		wr(A_SM, 8'h00);
		pulse(1);
		pin(1'b1);
		rd(A_LT, 8'h20);
		pin(1'b0);
		// One-shot pulse mode, then repeating pulse mode
		wr(A_CFG, 8'hE0);
		pulse(1);
		pin(1'b1);
		repeat (7) @(posedge pclk);
		pin(1'b0);
		rd(A_LT, 8'h20);
		wr(A_CFG, 8'hC0);
		pulse(1);
		pin(1'b1);
		repeat (7) @(posedge pclk);
		pin(1'b0);
		repeat (3) @(posedge pclk);
		pin(1'b1);
		rd(A_LT, 8'h20);
		wr(A_CFG, 8'h80);
		complete_run();
	end
endmodule
`default_nettype wire
